// ===== fpe_defines.svh
// constants for the flash program/erase control block
`ifndef FPE_DEFINES_SVH
`define FPE_DEFINES_SVH
// ----------------------------------------
// register offsets (register port)
// ----------------------------------------
`define FPE_CTL_OFS   4'h0
`define FPE_TST_OFS   4'h1
`define FPE_STAT_OFS  4'h2
`define FPE_RDAT_OFS  4'h3
`define FPE_RADR_OFS  4'h4
// ----------------------------------------
// control field positions
// ----------------------------------------
`define FPE_HVE_BIT   0
`define FPE_LAT_BIT   1
`define FPE_ERS_BIT   2
`define FPE_BTP_BIT   4
// ----------------------------------------
// reset values
// ----------------------------------------
`define FPE_CTL_RST   8'h10
`define FPE_TST_RST   8'h00
`endif

// ===== fpe_pkg.sv
// types for the flash program/erase control block
package fpe_pkg;
  // control register image
  typedef struct packed {
    logic boot_protect;
    logic erase_select;
    logic latch_enable;
    logic high_voltage_enable;
  } fpe_ctl_t;
  // array access from the cpu side
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [14:0] addr;
    logic [15:0] data;
  } fpe_arr_req_t;
  // sequencer states
  typedef enum logic [1:0] {
    FPE_IDLE   = 2'b00,
    FPE_ARMED  = 2'b01,
    FPE_LOADED = 2'b10,
    FPE_HV     = 2'b11
  } fpe_state_t;
endpackage : fpe_pkg

// ===== fpe_sync.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module fpe_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  // level in and out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;
  // first stage feeds only the second
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : fpe_sync

// ===== fpe_ctrl.sv
// flash program/erase control: interlocks, latches, test register
// Contract
// RQ1 - program mode: first array write latches address/data
// RQ2 - boot protect discards boot block program writes
// RQ3 - erase mode: any array write arms erase
// RQ4 - software times each program pulse
// RQ5 - software applies equal margin pulses
// RQ6 - software times each erase pulse
// RQ7 - software applies equal erase margin pulses
// RQ8 - software clears latch enable per location
// RQ9 - high voltage refused until latches loaded
// RQ10 - latches load only while latch enable set
// RQ11 - latch and high voltage on separate writes
// RQ12 - high voltage freezes mode and latch bits
// RQ13 - stop or wait aborts program/erase now
// RQ14 - software avoids stop/wait while programming
// RQ15 - test bits writable only in special mode
// RQ16 - special mode alone changes no behaviour
// RQ17 - array read result follows control bits
// RQ18 - loaded latches ignore further array writes
// RQ19 - high voltage without latch does nothing
// RQ20 - switch output follows high voltage bit
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "fpe_defines.svh"
module fpe_ctrl #(
  parameter int          AW         = 15,
  parameter int          DW         = 16,
  parameter logic [14:0] BOOT_BASE  = 15'h7800
) (
  // clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          nrst_i,
  // register port
  input  wire logic [3:0]    reg_addr_i,
  input  wire logic [7:0]    reg_wdata_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  output logic      [7:0]    reg_rdata_o,
  // array access port
  input  wire logic          arr_wr_i,
  input  wire logic          arr_rd_i,
  input  wire logic [AW-1:0] arr_addr_i,
  input  wire logic [DW-1:0] arr_wdata_i,
  input  wire logic [DW-1:0] arr_q_i,
  output logic      [DW-1:0] arr_rdata_o,
  output logic               arr_rvalid_o,
  output logic      [AW-1:0] arr_rd_addr_o,
  // array programming side
  output logic      [AW-1:0] prog_addr_o,
  output logic      [DW-1:0] prog_data_o,
  output logic               prog_erase_o,
  output logic               prog_boot_en_o,
  output logic               hv_switch_o,
  // mode lines from pins
  input  wire logic          special_mode_line_i,
  input  wire logic          stop_wait_i
);
  // ----------------------------------------
  // synchronised mode lines
  // ----------------------------------------
  logic special_mode_line_s;
  logic stop_s;
  fpe_sync #(.W(2)) u_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .d_i       ({special_mode_line_i, stop_wait_i}),
    .q_o       ({special_mode_line_s, stop_s})
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  fpe_pkg::fpe_ctl_t   ctl;
  fpe_pkg::fpe_state_t state;
  fpe_pkg::fpe_state_t next_state;
  logic                loaded;
  logic                boot_drop;
  logic [7:0]          tst;
  logic [AW-1:0]       lat_addr;
  logic [DW-1:0]       lat_data;
  // reset image of the control register, split into fields below
  localparam logic [7:0] CTL_RST = `FPE_CTL_RST;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire ctl_wr  = reg_wr_i && (reg_addr_i == `FPE_CTL_OFS);
  wire tst_wr  = reg_wr_i && (reg_addr_i == `FPE_TST_OFS);
  wire in_boot = (arr_addr_i >= BOOT_BASE);
  wire w_hve   = reg_wdata_i[`FPE_HVE_BIT];
  wire w_lat   = reg_wdata_i[`FPE_LAT_BIT];
  wire w_ers   = reg_wdata_i[`FPE_ERS_BIT];
  wire w_btp   = reg_wdata_i[`FPE_BTP_BIT];
  // first array write while latches open and empty
  wire lat_take = arr_wr_i && ctl.latch_enable && !loaded
                  && !ctl.high_voltage_enable;                   // RQ10 RQ18
  // boot protect discards program writes into the boot block
  wire lat_drop = lat_take && !ctl.erase_select && ctl.boot_protect && in_boot; // RQ2
  // high voltage only with latch already set and latches loaded
  wire hve_ok  = ctl_wr && w_hve && ctl.latch_enable && w_lat && loaded
                 && !stop_s;                                     // RQ9 RQ11 RQ19
  wire hve_set = ctl.high_voltage_enable;
  // mode bits frozen while high voltage is on
  wire mode_wr = ctl_wr && !hve_set;                             // RQ12
  wire lat_clr = mode_wr && !w_lat;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      // field by field so the byte layout and the struct layout stay independent
      ctl.boot_protect        <= CTL_RST[`FPE_BTP_BIT];
      ctl.erase_select        <= CTL_RST[`FPE_ERS_BIT];
      ctl.latch_enable        <= CTL_RST[`FPE_LAT_BIT];
      ctl.high_voltage_enable <= CTL_RST[`FPE_HVE_BIT];
    end else begin
      if (mode_wr) begin
        ctl.erase_select <= w_ers;                               // RQ12
        ctl.latch_enable <= w_lat;                               // RQ11
        ctl.boot_protect <= w_btp;
      end
      if (stop_s) begin
        ctl.high_voltage_enable <= 1'b0;                         // RQ13
      end else if (ctl_wr) begin
        ctl.high_voltage_enable <= hve_ok;                       // RQ9 RQ19
      end
    end
  end

  // ----------------------------------------
  // latch-loaded flag and programming latches
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      loaded    <= 1'b0;
      boot_drop <= 1'b0;
      lat_addr  <= '0;
      lat_data  <= '0;
    end else begin
      if (lat_take) begin
        loaded    <= 1'b1;                                       // RQ1 RQ3
        boot_drop <= lat_drop;                                   // RQ2
        lat_addr  <= arr_addr_i;                                 // RQ1
        lat_data  <= arr_wdata_i;                                // RQ1
      end else if (lat_clr) begin
        loaded    <= 1'b0;                                       // RQ8
        boot_drop <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // sequencer state, shown in status
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      fpe_pkg::FPE_IDLE:   if (ctl.latch_enable) next_state = fpe_pkg::FPE_ARMED;
      fpe_pkg::FPE_ARMED:  if (loaded) next_state = fpe_pkg::FPE_LOADED;
                           else if (!ctl.latch_enable) next_state = fpe_pkg::FPE_IDLE;
      fpe_pkg::FPE_LOADED: if (hve_set) next_state = fpe_pkg::FPE_HV;
                           else if (!loaded) next_state = fpe_pkg::FPE_IDLE;
      fpe_pkg::FPE_HV:     if (!hve_set) next_state = fpe_pkg::FPE_LOADED;
      default:             next_state = fpe_pkg::FPE_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) state <= fpe_pkg::FPE_IDLE;
    else         state <= next_state;
  end

  // ----------------------------------------
  // test register
  // ----------------------------------------
  // cleared whenever special mode drops so test cannot linger
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i)       tst <= `FPE_TST_RST;
    else if (!special_mode_line_s)  tst <= `FPE_TST_RST;                      // RQ15
    else if (tst_wr)   tst <= reg_wdata_i;                       // RQ15
  end

  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  // special mode alone alters nothing here; tst bits and status bit 3 show it
  wire [7:0] ctl_rd = {3'h0, ctl.boot_protect, 1'b0, ctl.erase_select,
                       ctl.latch_enable, ctl.high_voltage_enable}; // RQ16
  wire [7:0] st_rd  = {3'h0, boot_drop, special_mode_line_s, loaded, state};
  logic [7:0] next_rdata;
  always_comb begin
    case (reg_addr_i)
      `FPE_CTL_OFS:  next_rdata = ctl_rd;
      `FPE_TST_OFS:  next_rdata = tst;
      `FPE_STAT_OFS: next_rdata = st_rd;
      `FPE_RDAT_OFS: next_rdata = lat_data[7:0];
      `FPE_RADR_OFS: next_rdata = lat_addr[7:0];
      default:       next_rdata = 8'h00;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i)       reg_rdata_o <= 8'h00;
    else if (reg_rd_i) reg_rdata_o <= next_rdata;
    else               reg_rdata_o <= 8'h00;
  end

  // ----------------------------------------
  // array reads
  // ----------------------------------------
  // the address to the array is registered; arr_q_i answers that address
  wire show_lat  = ctl.latch_enable && !ctl.erase_select;        // RQ17
  wire rd_ok     = arr_rd_i && !hve_set;                         // RQ17
  logic rd_pend;
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      arr_rd_addr_o <= '0;
      rd_pend       <= 1'b0;
      arr_rvalid_o  <= 1'b0;
      arr_rdata_o   <= '0;
    end else begin
      rd_pend       <= rd_ok;
      arr_rd_addr_o <= show_lat ? lat_addr : arr_addr_i;         // RQ17
      arr_rvalid_o  <= rd_pend && !hve_set;
      arr_rdata_o   <= (rd_pend && !hve_set) ? arr_q_i : '0;
    end
  end

  // ----------------------------------------
  // programming outputs
  // ----------------------------------------
  // a dropped boot write keeps the switch off so nothing is programmed
  wire next_hv = hve_set && !stop_s && !boot_drop
                 && !(ctl_wr && !hve_ok);                        // RQ2 RQ13 RQ20
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      hv_switch_o    <= 1'b0;
      prog_addr_o    <= '0;
      prog_data_o    <= '0;
      prog_erase_o   <= 1'b0;
      prog_boot_en_o <= 1'b0;
    end else begin
      hv_switch_o    <= next_hv;                                 // RQ20
      prog_addr_o    <= lat_addr;
      prog_data_o    <= lat_data;
      prog_erase_o   <= ctl.erase_select;                        // RQ3
      prog_boot_en_o <= !ctl.boot_protect;                       // RQ3
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_arm;
    ctl_wr && w_lat && !w_hve && !hve_set;
  endsequence
  a_hv_needs_load: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(ctl.high_voltage_enable) |-> $past(loaded) && $past(ctl.latch_enable)) // RQ9
    else $error("high voltage set without loaded latches");
  a_combined_refused: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (ctl_wr && w_hve && !ctl.latch_enable) |=> !ctl.high_voltage_enable) // RQ11
    else $error("combined latch and high voltage write honoured");
  a_mode_frozen: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    hve_set |=> $stable(ctl.erase_select) && $stable(ctl.latch_enable)) // RQ12
    else $error("mode bits changed under high voltage");
  a_stop_aborts: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    stop_s |=> !ctl.high_voltage_enable ##1 !hv_switch_o)         // RQ13
    else $error("stop did not abort");
  a_tst_cleared: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !special_mode_line_s |=> tst == 8'h00)                                     // RQ15
    else $error("test register not cleared");
  a_latch_first: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (s_arm ##1 (arr_wr_i && ctl.latch_enable && !loaded)) |=>
      loaded && lat_addr == $past(arr_addr_i))                    // RQ1
    else $error("first array write not latched");
  a_latch_hold: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (arr_wr_i && (loaded || !ctl.latch_enable)) |=> $stable(lat_addr)
      && $stable(lat_data))                                       // RQ10
    else $error("latches changed by ignored write");
  a_read_ignored: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (arr_rd_i && hve_set) |=> ##1 !arr_rvalid_o)                  // RQ17
    else $error("read answered under high voltage");
  a_boot_drop: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    boot_drop |=> !hv_switch_o)                                   // RQ2
    else $error("boot block programmed while protected");
  a_switch_follow: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    hv_switch_o |-> $past(ctl.high_voltage_enable))               // RQ20
    else $error("switch on without high voltage bit");
  a_erase_arms: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (arr_wr_i && ctl.latch_enable && ctl.erase_select && !loaded && !hve_set)
      |=> loaded)                                                 // RQ3
    else $error("erase write did not arm");
  a_rd_lat_addr: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (arr_rd_i && show_lat) |=> arr_rd_addr_o == $past(lat_addr))  // RQ17
    else $error("read did not address the programmed location");
endmodule : fpe_ctrl

// ===== fpe_flash_model.sv
// flash array model standing behind the program/erase control block
`timescale 1ns/1ps
module fpe_flash_model #(
  parameter logic [14:0] BOOT_BASE = 15'h7800
) (
  // clock
  input  wire logic        sys_clk_i,
  // read and program side of the control block
  input  wire logic [14:0] rd_addr_i,
  input  wire logic [14:0] prog_addr_i,
  input  wire logic [15:0] prog_data_i,
  input  wire logic        erase_i,
  input  wire logic        boot_en_i,
  input  wire logic        hv_i,
  // cell contents at the read address
  output logic      [15:0] q_o
);
  logic [15:0] mem [0:32767];
  logic        hv_q = 1'b0;
  // erased cells read all ones
  initial for (int i = 0; i < 32768; i++) mem[i] = 16'hffff;
  assign q_o = mem[rd_addr_i];
  // a pulse acts once at its rising edge; programming can only clear bits
  always @(posedge sys_clk_i) begin
    hv_q <= hv_i;
    if (hv_i === 1'b1 && hv_q !== 1'b1) begin
      if (!erase_i) mem[prog_addr_i] <= mem[prog_addr_i] & prog_data_i;
      else for (int i = 0; i < 32768; i++)
        if (i < BOOT_BASE || boot_en_i) mem[i] <= 16'hffff;
    end
  end
endmodule : fpe_flash_model

// ===== flash_program_erase_control_test.sv
// self-checking bench for the flash program/erase control block
`timescale 1ns/1ps
`include "fpe_defines.svh"
module flash_program_erase_control_test;
  logic        sys_clk_i, nrst_i, reg_wr_i, reg_rd_i, arr_wr_i, arr_rd_i, vb;
  logic        special_mode_line_i, stop_wait_i, arr_rvalid_o, prog_erase_o;
  logic        prog_boot_en_o, hv_switch_o;
  logic [3:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o, rv;
  logic [14:0] arr_addr_i, arr_rd_addr_o, prog_addr_o, a;
  logic [15:0] arr_wdata_i, arr_q_i, arr_rdata_o, prog_data_o, av, lfsr;
  logic [15:0] em [int];
  int          n_errors, compares, m_ctl, m_ld, m_la, m_dat, m_hv, m_stop;

  fpe_ctrl dut (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .arr_wr_i, .arr_rd_i, .arr_addr_i, .arr_wdata_i, .arr_q_i, .arr_rdata_o,
    .arr_rvalid_o, .arr_rd_addr_o, .prog_addr_o, .prog_data_o, .prog_erase_o,
    .prog_boot_en_o, .hv_switch_o, .special_mode_line_i, .stop_wait_i);
  fpe_flash_model arr (.sys_clk_i, .rd_addr_i(arr_rd_addr_o), .prog_addr_i(prog_addr_o),
    .prog_data_i(prog_data_o), .erase_i(prog_erase_o), .boot_en_i(prog_boot_en_o),
    .hv_i(hv_switch_o), .q_o(arr_q_i));

  // clock, and a watchdog sized well beyond the expected run
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #(5 * 20000);
    n_errors++;
    final_report;
  end

  task automatic final_report;
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic cmp(logic [15:0] g, logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic chk_reg(logic [7:0] g, logic [7:0] e); cmp({8'h00, g}, {8'h00, e}); endtask : chk_reg
  task automatic chk_arr(logic [15:0] g, logic [15:0] e); cmp(g, e); endtask : chk_arr
  task automatic chk_bit(logic g, logic e); cmp({15'h0, g}, {15'h0, e}); endtask : chk_bit
  function automatic logic [15:0] lfsr_next(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  function automatic logic [15:0] rdm(int x);
    return em.exists(x) ? em[x] : 16'hffff;
  endfunction : rdm

  // reference model of a control write: interlocks, then the cells it would touch
  function automatic void m_wr(int d);
    int ok;
    ok = d[0] && d[1] && m_ctl[1] && m_ld && !m_stop;
    if (m_ctl[0]) m_ctl[0] = ok;
    else m_ctl = (d & 'h16) | ok;
    if (!m_ctl[1]) m_ld = 0;
    m_hv = m_ctl[0] && !(m_ctl[4] && !m_ctl[2] && m_la >= 32'h7800);
    if (m_hv && !m_ctl[2]) em[m_la] = rdm(m_la) & m_dat[15:0];
    if (m_hv && m_ctl[2]) foreach (em[k]) if (k < 32'h7800 || !m_ctl[4]) em[k] = 16'hffff;
  endfunction : m_wr

  // bus cycles: drive after an edge, hold through the sampling edge
  task automatic reg_wr(logic [3:0] ra, logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= ra;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    if (ra == `FPE_CTL_OFS) m_wr(d);
  endtask : reg_wr
  task automatic reg_rd(logic [3:0] ra);
    @(posedge sys_clk_i);
    reg_addr_i <= ra;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    rv = reg_rdata_o;
  endtask : reg_rd
  task automatic arr_wr(logic [14:0] wa, logic [15:0] d);
    @(posedge sys_clk_i);
    arr_addr_i  <= wa;
    arr_wdata_i <= d;
    arr_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    arr_wr_i <= 1'b0;
    if (m_ctl[1] && !m_ld && !m_ctl[0]) begin
      m_la  = wa;
      m_dat = d;
      m_ld  = 1;
    end
  endtask : arr_wr
  task automatic rd_chk(logic [14:0] ra);
    @(posedge sys_clk_i);
    arr_addr_i <= ra;
    arr_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    arr_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    vb = arr_rvalid_o;
    av = arr_rdata_o;
    chk_bit(vb, !m_ctl[0]);
    if (!m_ctl[0]) chk_arr(av, rdm((m_ctl[1] && !m_ctl[2]) ? m_la : ra));
  endtask : rd_chk
  task automatic chk_ctl;
    reg_rd(`FPE_CTL_OFS);
    chk_reg(rv, m_ctl[7:0]);
  endtask : chk_ctl
  task automatic chk_out;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk_bit(hv_switch_o, m_hv[0]);
    chk_bit(prog_erase_o, m_ctl[2]);
    chk_bit(prog_boot_en_o, !m_ctl[4]);
    if (m_ld) chk_arr({1'b0, prog_addr_o}, m_la[15:0]);
    if (m_ld) chk_arr(prog_data_o, m_dat[15:0]);
  endtask : chk_out
  // one high-voltage pulse, trying to upset the mode while it is on
  task automatic pulse(logic [7:0] base);
    reg_wr(`FPE_CTL_OFS, base | 8'h01);
    chk_out;
    reg_wr(`FPE_CTL_OFS, (base ^ 8'h14) | 8'h03);
    chk_ctl;
    rd_chk(m_la[14:0] ^ 15'h0002);
    reg_wr(`FPE_CTL_OFS, (base ^ 8'h06) | 8'h01);
    chk_ctl;
    reg_wr(`FPE_CTL_OFS, base);
    chk_out;
  endtask : pulse
  // software sequence: pulse until verified, equal margin, re-verify, drop latch
  task automatic prog(logic [14:0] pa, logic [15:0] d, logic [7:0] base, logic [15:0] tgt);
    int n;
    n = 0;
    reg_wr(`FPE_CTL_OFS, base);
    arr_wr(pa, d);
    arr_wr(pa ^ 15'h0001, ~d);
    chk_out;
    reg_rd(`FPE_RDAT_OFS);
    chk_reg(rv, m_dat[7:0]);
    reg_rd(`FPE_RADR_OFS);
    chk_reg(rv, m_la[7:0]);
    do begin
      pulse(base);
      n++;
      rd_chk(pa);
    end while (av !== tgt && n < 4);
    repeat (n) pulse(base);
    rd_chk(pa);
    reg_wr(`FPE_CTL_OFS, base & 8'hf5);
    chk_out;
  endtask : prog

  // main sequence
  initial begin
    {nrst_i, reg_wr_i, reg_rd_i, arr_wr_i, arr_rd_i, special_mode_line_i, stop_wait_i} = '0;
    {reg_addr_i, reg_wdata_i, arr_addr_i, arr_wdata_i} = '0;
    {n_errors, compares, m_ld, m_la, m_dat, m_hv, m_stop} = '0;
    m_ctl = 'h10;
    lfsr  = 16'h0004;
    repeat (12) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    chk_ctl;
    chk_out;
    reg_rd(4'hf);
    chk_reg(rv, 8'h00);
    reg_wr(`FPE_CTL_OFS, 8'h11);
    chk_ctl;
    reg_wr(`FPE_CTL_OFS, 8'h13);
    chk_ctl;
    reg_wr(`FPE_CTL_OFS, 8'h13);
    chk_ctl;
    reg_wr(`FPE_CTL_OFS, 8'h10);
    arr_wr(15'h0005, 16'h1234);
    reg_rd(`FPE_STAT_OFS);
    chk_bit(rv[2], m_ld[0]);
    repeat (3) begin
      lfsr = lfsr_next(lfsr);
      a    = {1'b0, lfsr[13:0]};
      lfsr = lfsr_next(lfsr);
      prog(a, lfsr, 8'h12, lfsr);
      rd_chk(a);
    end
    prog(15'h7900, 16'h0000, 8'h12, 16'h0000);
    prog(a, lfsr, 8'h06, 16'hffff);
    rd_chk(a);
    reg_wr(`FPE_CTL_OFS, 8'h12);
    arr_wr(a, 16'h00ff);
    reg_wr(`FPE_CTL_OFS, 8'h13);
    chk_out;
    @(posedge sys_clk_i);
    stop_wait_i <= 1'b1;
    m_stop   = 1;
    m_ctl[0] = 0;
    m_hv     = 0;
    for (int i = 0; i < 8 && hv_switch_o !== 1'b0; i++) @(posedge sys_clk_i);
    chk_out;
    chk_ctl;
    reg_wr(`FPE_CTL_OFS, 8'h13);
    chk_ctl;
    // a stop taken mid-program is left here through a reset applied as stop drops
    @(posedge sys_clk_i);
    stop_wait_i <= 1'b0;
    nrst_i      <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    {m_ld, m_hv, m_stop} = '0;
    m_ctl = 'h10;
    chk_ctl;
    chk_out;
    reg_wr(`FPE_CTL_OFS, 8'h10);
    reg_wr(`FPE_TST_OFS, 8'ha5);
    reg_rd(`FPE_TST_OFS);
    chk_reg(rv, 8'h00);
    @(posedge sys_clk_i);
    special_mode_line_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    prog(15'h0123, 16'h5a5a, 8'h12, 16'h5a5a);
    reg_wr(`FPE_TST_OFS, 8'ha5);
    reg_rd(`FPE_TST_OFS);
    chk_reg(rv, 8'ha5);
    @(posedge sys_clk_i);
    special_mode_line_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    reg_rd(`FPE_TST_OFS);
    chk_reg(rv, 8'h00);
    final_report;
  end
endmodule : flash_program_erase_control_test
